// >>> rtl/fault_sup_pkg.sv
/*
  Constants for the LED driver fault supervisor: register map, field
  positions, reset values, clear-interval counts and controller states.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package fault_sup_pkg;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFFSET  = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFFSET  = 8'h0c;
  localparam logic [7:0]  DETECT_OFFSET    = 8'h10;

  // Control register fields and register reset values
  localparam int          CTRL_LOWFREQ_BIT = 0;
  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
  localparam logic [7:0]  MASK_RESET_VALUE = 8'h00;

  // Interrupt/status event bits
  localparam int EV_LATCH     = 0;
  localparam int EV_CLEARED   = 1;
  localparam int EV_AUTO      = 2;
  localparam int EV_PSHORT    = 3;
  localparam int EV_SUPPLY_UNDERVOLTAGE_LOCKOUT      = 4;
  localparam int EV_WIDTH     = 5;

  localparam int          NUM_STRINGS      = 4;
  // Clear interval in switching-clock cycles, strictly more than this
  localparam logic [15:0] CLEAR_CYCLES_STD = 16'h8000;
  localparam logic [15:0] CLEAR_CYCLES_LOW = 16'h2000;

  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_RUN     = 2'b01,
    ST_LATCHED = 2'b10
  } sup_state_t;
endpackage : fault_sup_pkg

// >>> rtl/sup_if.sv
/*
  Interface carrying the clear-timer request and result between the
  supervisor and its clear timer. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface sup_if;
  logic       en_low;
  logic       dim_low;
  logic       low_freq;
  logic       sw_tick;
  logic       clear_done;
  modport sup   (output en_low, output dim_low, output low_freq, output sw_tick, input clear_done);
  modport timer (input en_low, input dim_low, input low_freq, input sw_tick, output clear_done);
endinterface : sup_if
`default_nettype wire

// >>> rtl/clear_timer.sv
/*
  Clear-interval timer: counts switching-clock cycles of a held clearing
  condition. Assumes sw_tick is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module clear_timer
  import fault_sup_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  sup_if.timer      bus
);
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic        done_reg;
  logic        done_next;
  logic [16:0] limit;

  always_comb begin
    // The shorter low-freq interval applies to the dim-low method only; enable-low always waits the full one
    limit     = (bus.low_freq && bus.dim_low) ? {1'b0, CLEAR_CYCLES_LOW} : {1'b0, CLEAR_CYCLES_STD};
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (!(bus.en_low || bus.dim_low)) begin
      cnt_next = 17'h0_0000;
    end else if (bus.sw_tick && cnt_reg <= limit) begin
      cnt_next = cnt_reg + 17'h0_0001;
      // Strictly more than the interval: fires once when it passes the limit
      done_next = (cnt_reg == limit);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 17'h0_0000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign bus.clear_done = done_reg;
endmodule : clear_timer
`default_nettype wire

// >>> rtl/fault_supervisor.sv
/*
  Fault supervision and recovery for a boost LED driver: fault inputs in,
  boost, disconnect and sink enables plus fault flag out, APB registers.
  Assumes fault detections and host inputs are synchronous to pclk and
  sw_tick marks each cycle of the internal switching clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor
  import fault_sup_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   enable_in,
  input  wire logic                   dim_in,
  input  wire logic                   sw_tick,
  input  wire logic                   current_set_pin_short,
  input  wire logic                   freq_set_sync_pin_short,
  input  wire logic                   overvoltage_sense_trip,
  input  wire logic                   overvoltage_release,
  input  wire logic                   boost_output_undervoltage,
  input  wire logic [NUM_STRINGS-1:0] led_short_threshold_above,
  input  wire logic [NUM_STRINGS-1:0] led_sink_regulating,
  input  wire logic [NUM_STRINGS-1:0] led_pin_low,
  input  wire logic                   over_temp,
  input  wire logic                   thermal_hysteresis_clear,
  input  wire logic                   supply_undervoltage_lockout,
  input  wire logic                   disconnect_overcurrent,
  input  wire logic                   boost_switch_node_overcurrent,
  input  wire logic                   boost_switch_node_overvoltage,
  output logic                        boost_enable,
  output logic                        disconnect_enable,
  output logic      [NUM_STRINGS-1:0] sink_enable,
  output logic                        soft_start,
  output logic                        switching_clock_out,
  output logic                        fault_n,
  output logic                        irq
);
  sup_if ctl ();

  sup_state_t              state_reg, state_next;
  logic                    ot_reg, ot_next;
  logic                    ovp_reg, ovp_next;
  logic [NUM_STRINGS-1:0]  dis_reg, dis_next;
  logic                    dim_d_reg;
  logic                    boost_reg, boost_next;
  logic                    disc_reg, disc_next;
  logic [NUM_STRINGS-1:0]  sink_reg, sink_next;
  logic                    ss_reg, ss_next;
  logic                    clk_reg, clk_next;
  logic                    fault_n_reg, fault_n_next;
  logic                    fs_seen_reg, fs_seen_next;
  logic [31:0]             ctrl_reg, ctrl_next;
  logic [EV_WIDTH-1:0]     ist_reg, ist_next;
  logic [EV_WIDTH-1:0]     imask_reg, imask_next;
  logic [31:0]             prdata_next;
  logic                    pready_next, pslverr_next, irq_next;
  logic                    latch_fault, auto_fault, dim_rise;
  logic [EV_WIDTH-1:0]     events;
  logic                    wr, rd, known;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  assign ctl.en_low   = ~enable_in && state_reg == ST_LATCHED;
  assign ctl.dim_low  = enable_in && ~dim_in && state_reg == ST_LATCHED;
  assign ctl.low_freq = ctrl_reg[CTRL_LOWFREQ_BIT];
  assign ctl.sw_tick  = sw_tick;

  clear_timer u_clear_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (ctl)
  );

  always_comb begin
    latch_fault = disconnect_overcurrent | boost_switch_node_overcurrent
                  | boost_switch_node_overvoltage;
    dim_rise    = dim_in & ~dim_d_reg;
    // Overtemp holds until the hysteresis point is passed
    ot_next     = over_temp ? 1'b1 : (thermal_hysteresis_clear ? 1'b0 : ot_reg);
    ovp_next    = overvoltage_sense_trip ? 1'b1 : (overvoltage_release ? 1'b0 : ovp_reg);
    auto_fault  = freq_set_sync_pin_short | boost_output_undervoltage | ot_reg;
    state_next  = state_reg;
    // Priority: lockout forces ST_OFF, a clear beats a held latching fault
    if (supply_undervoltage_lockout) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (latch_fault) begin
            state_next = ST_LATCHED;
          end else if (enable_in && dim_in) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (latch_fault) begin
            state_next = ST_LATCHED;
          end else if (!enable_in) begin
            state_next = ST_OFF;
          end
        end
        ST_LATCHED: begin
          // A still-present fault re-latches the cycle after the clear
          if (ctl.clear_done) begin
            state_next = ST_OFF;
          end
        end
        default: state_next = ST_OFF;
      endcase
    end
  end

  always_comb begin
    dis_next = dis_reg;
    for (int i = 0; i < NUM_STRINGS; i++) begin
      if (led_short_threshold_above[i] && led_sink_regulating[i] && |(led_pin_low & ~(4'b0001 << i))) begin
        dis_next[i] = 1'b1;
      end else if (!led_short_threshold_above[i] || dim_rise) begin
        dis_next[i] = 1'b0;
      end
    end
    if (state_reg != ST_RUN) begin
      dis_next = '0;
    end
  end

  always_comb begin
    boost_next   = 1'b0;
    disc_next    = 1'b0;
    sink_next    = '0;
    fault_n_next = 1'b1;
    fs_seen_next = fs_seen_reg | freq_set_sync_pin_short;
    ss_next      = 1'b0;
    clk_next     = clk_reg;
    if (sw_tick && !supply_undervoltage_lockout) begin
      clk_next = ~clk_reg;
    end
    if (supply_undervoltage_lockout) begin
      clk_next = 1'b0;
    end else if (state_next == ST_LATCHED) begin
      fault_n_next = 1'b0;
    end else if (state_next == ST_RUN) begin
      disc_next  = 1'b1;
      boost_next = 1'b1;
      sink_next  = {NUM_STRINGS{dim_in}} & ~dis_next;
      if (current_set_pin_short) begin
        boost_next = 1'b0;
        sink_next  = '0;
      end
      if (ovp_next) begin
        boost_next = 1'b0;
      end
      if (boost_output_undervoltage) begin
        boost_next   = 1'b0;
        sink_next    = '0;
        fault_n_next = 1'b0;
      end
      if (freq_set_sync_pin_short || ot_next) begin
        boost_next   = 1'b0;
        disc_next    = 1'b0;
        sink_next    = '0;
        fault_n_next = 1'b0;
      end
      if (!auto_fault && fs_seen_reg) begin
        ss_next      = 1'b1;
        fs_seen_next = 1'b0;
      end
    end
  end

  always_comb begin
    wr     = psel & penable & pwrite;
    rd     = psel & penable & ~pwrite;
    known  = addr_hit(paddr, CTRL_OFFSET) | addr_hit(paddr, STATUS_OFFSET) | addr_hit(paddr, IRQ_STAT_OFFSET)
             | addr_hit(paddr, IRQ_MASK_OFFSET) | addr_hit(paddr, DETECT_OFFSET);
    events = '0;
    events[EV_LATCH]   = (state_next == ST_LATCHED) && (state_reg != ST_LATCHED);
    events[EV_CLEARED] = ctl.clear_done;
    events[EV_AUTO]    = auto_fault | current_set_pin_short;
    events[EV_PSHORT]  = |(dis_next & ~dis_reg);
    events[EV_SUPPLY_UNDERVOLTAGE_LOCKOUT]    = supply_undervoltage_lockout;
    ctrl_next    = ctrl_reg;
    imask_next   = imask_reg;
    ist_next     = ist_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = psel & ~penable;
    pslverr_next = 1'b0;
    if (wr && pready_reg_q()) begin
      if (addr_hit(paddr, CTRL_OFFSET)) begin
        ctrl_next = {31'h0000_0000, pwdata[CTRL_LOWFREQ_BIT]};
      end
      if (addr_hit(paddr, IRQ_MASK_OFFSET)) begin
        imask_next = pwdata[EV_WIDTH-1:0];
      end
    end
    if (psel && !penable) begin
      pslverr_next = ~known;
      if (!pwrite) begin
        case (paddr)
          CTRL_OFFSET:     prdata_next = ctrl_reg;
          STATUS_OFFSET:   prdata_next = {24'h00_0000, dis_reg, fault_n_reg, ctl.clear_done, state_reg};
          IRQ_STAT_OFFSET: prdata_next = {27'h000_0000, ist_reg};
          IRQ_MASK_OFFSET: prdata_next = {27'h000_0000, imask_reg};
          DETECT_OFFSET:   prdata_next = {29'h0000_0000, latch_fault, auto_fault, ovp_reg};
          default:         prdata_next = 32'h0000_0000;
        endcase
      end
    end
    // Read clears, but an event in the same cycle survives
    if (rd && pready && addr_hit(paddr, IRQ_STAT_OFFSET)) begin
      ist_next = '0;
    end
    ist_next = ist_next | events;
    irq_next = |(ist_next & imask_next);
  end

  function automatic logic pready_reg_q();
    pready_reg_q = pready;
  endfunction : pready_reg_q

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_OFF;
      ot_reg      <= 1'b0;
      ovp_reg     <= 1'b0;
      dis_reg     <= '0;
      dim_d_reg   <= 1'b0;
      boost_reg   <= 1'b0;
      disc_reg    <= 1'b0;
      sink_reg    <= '0;
      ss_reg      <= 1'b0;
      clk_reg     <= 1'b0;
      fault_n_reg <= 1'b1;
      fs_seen_reg <= 1'b0;
      ctrl_reg    <= CTRL_RESET_VALUE;
      ist_reg     <= '0;
      imask_reg   <= MASK_RESET_VALUE[EV_WIDTH-1:0];
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ot_reg      <= ot_next;
      ovp_reg     <= ovp_next;
      dis_reg     <= dis_next;
      dim_d_reg   <= dim_in;
      boost_reg   <= boost_next;
      disc_reg    <= disc_next;
      sink_reg    <= sink_next;
      ss_reg      <= ss_next;
      clk_reg     <= clk_next;
      fault_n_reg <= fault_n_next;
      fs_seen_reg <= fs_seen_next;
      ctrl_reg    <= ctrl_next;
      ist_reg     <= ist_next;
      imask_reg   <= imask_next;
      prdata      <= prdata_next;
      pready      <= pready_next;
      pslverr     <= pslverr_next;
      irq         <= irq_next;
    end
  end

  assign boost_enable        = boost_reg;
  assign disconnect_enable   = disc_reg;
  assign sink_enable         = sink_reg;
  assign soft_start          = ss_reg;
  assign switching_clock_out = clk_reg;
  assign fault_n             = fault_n_reg;
endmodule : fault_supervisor
`default_nettype wire

// >>> sim/fault_supervisor_chk.sv
/* Port assertions for fault_supervisor.
   Assumes inputs synchronous to pclk; bound to every instance below. */
`timescale 1ns/1ps
`default_nettype none
module fault_supervisor_chk
  import fault_sup_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       sw_tick,
  input wire logic       current_set_pin_short,
  input wire logic       freq_set_sync_pin_short,
  input wire logic       overvoltage_sense_trip,
  input wire logic       boost_output_undervoltage,
  input wire logic [3:0] led_short_threshold_above,
  input wire logic [3:0] led_sink_regulating,
  input wire logic [3:0] led_pin_low,
  input wire logic       over_temp,
  input wire logic       supply_undervoltage_lockout,
  input wire logic       disconnect_overcurrent,
  input wire logic       boost_switch_node_overcurrent,
  input wire logic       boost_switch_node_overvoltage,
  input wire logic       boost_enable,
  input wire logic       disconnect_enable,
  input wire logic [3:0] sink_enable,
  input wire logic       switching_clock_out,
  input wire logic       fault_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic latch_in;
  logic all_off;
  logic lock;
  assign latch_in = disconnect_overcurrent | boost_switch_node_overcurrent | boost_switch_node_overvoltage;
  assign all_off  = !boost_enable && !disconnect_enable && sink_enable == 4'h0;
  assign lock     = supply_undervoltage_lockout;
  // A clear in the same cycle lets the flag rise once before a held fault re-latches
  chk_latch_off:
    assert property (latch_in && !lock |=> (all_off && (!fault_n || !$past(fault_n))) [*2])
      else $error("latch not off");
  chk_current_set_pin_stop:
    assert property (current_set_pin_short |=> !boost_enable && sink_enable == 4'h0) else $error("current_set_pin");
  chk_fset_off:
    assert property (freq_set_sync_pin_short && !lock |=> all_off && !fault_n) else $error("fset");
  chk_ovp_stop:
    assert property (overvoltage_sense_trip |=> !boost_enable) else $error("ovp");
  chk_uvp_flag:
    assert property (boost_output_undervoltage && !lock |=> !boost_enable && sink_enable == 4'h0 && !fault_n)
      else $error("uvp");
  chk_temp_off:
    assert property (over_temp && !lock |=> all_off && !fault_n) else $error("temp");
  chk_lockout_quiet:
    assert property (lock && !freq_set_sync_pin_short && !boost_output_undervoltage && !over_temp && !latch_in
      |=> all_off && fault_n) else $error("lockout");
  chk_string_drop:
    assert property (led_short_threshold_above[0] && led_sink_regulating[0] && |led_pin_low[3:1]
      |=> !sink_enable[0]) else $error("string kept");
  // Clock out must keep running while flagged, so neighbours stay in sync
  chk_clk_latched:
    assert property (sw_tick && !fault_n && !lock |=> switching_clock_out != $past(switching_clock_out))
      else $error("clock stopped");
endmodule : fault_supervisor_chk
bind fault_supervisor fault_supervisor_chk u_chk (.pclk, .presetn, .sw_tick, .current_set_pin_short,
  .freq_set_sync_pin_short, .overvoltage_sense_trip, .boost_output_undervoltage, .led_short_threshold_above,
  .led_sink_regulating, .led_pin_low, .over_temp, .supply_undervoltage_lockout, .disconnect_overcurrent,
  .boost_switch_node_overcurrent, .boost_switch_node_overvoltage, .boost_enable, .disconnect_enable,
  .sink_enable, .switching_clock_out, .fault_n);
`default_nettype wire

// >>> sim/host_model.sv
/* Host model: drives enable and dimming levels on request.
   Assumes tasks are called from pclk rising edges. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic pclk,
  output var  logic enable_in,
  output var  logic dim_in
);
  initial begin
    enable_in = 1'b0;
    dim_in    = 1'b0;
  end
  task automatic set_lv(input logic en, input logic dim);
    @(posedge pclk);
    enable_in <= en;
    dim_in    <= dim;
  endtask : set_lv
  // Caller picks n past the interval, or short of it to test a restart
  task automatic hold_clear(input logic use_en, input int n);
    set_lv(!use_en, 1'b0);
    repeat (n) @(posedge pclk);
  endtask : hold_clear
endmodule : host_model
`default_nettype wire

// >>> sim/fault_supervisor_tb.sv
/* Bench for fault_supervisor: APB, fault inputs and a host model.
   Assumes the low-freq interval is chosen through CTRL to keep runs short. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end
module fault_supervisor_tb
  import fault_sup_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sw_tick;
  logic        enable_in;
  logic        dim_in;
  logic [5:0]  flt;
  logic [1:0]  rel;
  logic [2:0]  lat;
  logic [3:0]  above;
  logic [3:0]  regl;
  logic [3:0]  pinl;
  logic        boost_enable;
  logic        disconnect_enable;
  logic        soft_start;
  logic [3:0]  sink_enable;
  logic        fault_n;
  logic        irq;
  int          n_mismatch;
  int          num_checks;

  fault_supervisor DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .enable_in, .dim_in, .sw_tick, .current_set_pin_short(flt[0]), .freq_set_sync_pin_short(flt[1]),
    .overvoltage_sense_trip(flt[2]), .boost_output_undervoltage(flt[3]), .over_temp(flt[4]),
    .supply_undervoltage_lockout(flt[5]), .overvoltage_release(rel[0]), .thermal_hysteresis_clear(rel[1]),
    .led_short_threshold_above(above), .led_sink_regulating(regl), .led_pin_low(pinl),
    .disconnect_overcurrent(lat[0]), .boost_switch_node_overcurrent(lat[1]),
    .boost_switch_node_overvoltage(lat[2]), .boost_enable, .disconnect_enable, .sink_enable, .soft_start,
    .switching_clock_out(), .fault_n, .irq);
  host_model host (.pclk, .enable_in, .dim_in);

  always #20 pclk = ~pclk;
  always @(posedge pclk) sw_tick <= ~sw_tick;

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      $display("BAD %0t wait timed out", $time);
      test_done();
    end
  endtask : bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    bound(k, 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic outs(input logic [6:0] e, input string m);
    `CHK({boost_enable, disconnect_enable, sink_enable, fault_n}, e, m)
  endtask : outs
  task automatic wait_run();
    int k;
    k = 0;
    while (boost_enable !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    bound(k, 400);
    tick(2);
    outs(7'h7f, "run");
  endtask : wait_run

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q, CTRL_RESET_VALUE, "ctrl reset")
    apb(1'b0, IRQ_MASK_OFFSET, 32'h0, q, e);
    `CHK(q[7:0], MASK_RESET_VALUE, "mask reset")
    apb(1'b1, 8'h40, 32'hffff_ffff, q, e);
    `CHK(e, 1'b1, "unmapped write")
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK({e, q}, {1'b1, 32'h0}, "unmapped read")
    apb(1'b1, CTRL_OFFSET, 32'h1, q, e);
    apb(1'b0, CTRL_OFFSET, 32'h0, q, e);
    `CHK(q[CTRL_LOWFREQ_BIT], 1'b1, "low freq")
  endtask : t_regs
  task automatic t_auto();
    logic [6:0] ex [6] = '{7'h21, 7'h00, 7'h3f, 7'h20, 7'h00, 7'h01};
    host.set_lv(1'b1, 1'b1);
    wait_run();
    for (int i = 0; i < 6; i++) begin
      flt <= 6'h01 << i;
      tick(3);
      outs(ex[i], "fault response");
      flt <= 6'h00;
      rel <= 2'h3;
      host.set_lv(1'b1, i != 5);
      rel <= 2'h0;
      host.set_lv(1'b1, 1'b1);
      `CHK(soft_start, i == 1, "soft start")
      wait_run();
    end
  endtask : t_auto
  task automatic t_pshort();
    above <= 4'h1;
    pinl  <= 4'h2;
    tick(3);
    outs(7'h7d, "string off");
    above <= 4'h0;
    tick(3);
    outs(7'h7f, "pin dropped");
    above <= 4'h1;
    tick(3);
    pinl <= 4'h0;
    tick(3);
    outs(7'h7d, "still off");
    host.set_lv(1'b1, 1'b0);
    host.set_lv(1'b1, 1'b1);
    wait_run();
    above <= 4'h0;
  endtask : t_pshort
  task automatic t_latch();
    logic [31:0] q;
    logic        e;
    int          k;
    lat <= 3'h1;
    tick(1);
    lat <= 3'h0;
    tick(2);
    outs(7'h00, "latched");
    `CHK(irq, 1'b0, "irq masked")
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1 << EV_LATCH, q, e);
    tick(1);
    `CHK(irq, 1'b1, "irq raised")
    apb(1'b0, IRQ_STAT_OFFSET, 32'h0, q, e);
    `CHK(q[EV_LATCH], 1'b1, "latch event")
    tick(1);
    `CHK(irq, 1'b0, "irq cleared")
    apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
    `CHK(q, {28'h000_0000, 2'b00, ST_LATCHED}, "status latched")
    host.set_lv(1'b1, 1'b0);
    host.set_lv(1'b1, 1'b1);
    tick(4);
    outs(7'h00, "dim ignored");
    host.hold_clear(1'b0, 9000);
    host.set_lv(1'b1, 1'b1);
    host.hold_clear(1'b0, 9000);
    `CHK(fault_n, 1'b0, "early clear")
    host.hold_clear(1'b0, 8000);
    `CHK(fault_n, 1'b1, "dim clear")
    host.set_lv(1'b1, 1'b1);
    wait_run();
    lat <= 3'h2;
    tick(3);
    outs(7'h00, "latched");
    // Enable-low clear with the fault still held; low-freq mode must not shorten it
    host.set_lv(1'b0, 1'b0);
    k = 0;
    for (int j = 1; j <= 68000; j++) begin
      @(posedge pclk);
      if (fault_n === 1'b1 && k == 0)
        k = j;
    end
    `CHK(k > 0, 1'b1, "flag released")
    // Ticks come every other pclk, so the full interval spans twice its count
    `CHK(k > 2 * int'(CLEAR_CYCLES_STD), 1'b1, "enable clear")
    `CHK(fault_n, 1'b0, "relatched")
    lat <= 3'h0;
    host.set_lv(1'b1, 1'b1);
    tick(4);
    outs(7'h00, "still latched");
    flt <= 6'h20;
    tick(3);
    outs(7'h01, "lockout");
    flt <= 6'h00;
    host.set_lv(1'b1, 1'b0);
    host.set_lv(1'b1, 1'b1);
    wait_run();
    lat <= 3'h4;
    tick(1);
    lat <= 3'h0;
    tick(2);
    outs(7'h00, "latched");
    flt <= 6'h20;
    tick(3);
    outs(7'h01, "lockout");
    flt <= 6'h00;
    host.set_lv(1'b1, 1'b0);
    host.set_lv(1'b1, 1'b1);
    wait_run();
  endtask : t_latch

  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    sw_tick    = 1'b0;
    flt        = 6'h00;
    rel        = 2'h0;
    lat        = 3'h0;
    above      = 4'h0;
    regl       = 4'hf;
    pinl       = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    t_regs();
    t_auto();
    t_pshort();
    t_latch();
    test_done();
  end
endmodule : fault_supervisor_tb
`default_nettype wire
